/* shared/vbs_pkg.sv */
package vbs_pkg;
  // data path widths
  localparam int VBS_DW = 64;
  localparam int VBS_BYTE = 8;
  // transfer width encodings on the cycle decode port
  localparam logic [1:0] VBS_W_D08 = 2'h0;
  localparam logic [1:0] VBS_W_D16 = 2'h1;
  localparam logic [1:0] VBS_W_D32 = 2'h2;
  localparam logic [1:0] VBS_W_D64 = 2'h3;
  // lane select for a 16-bit transfer
  localparam logic VBS_LANE_LO = 1'b0;
  localparam logic VBS_LANE_HI = 1'b1;
  // swap patterns driven to the lane multiplexers
  typedef enum logic [2:0] {
    VBS_SW_NONE = 3'h0,
    VBS_SW_D16L = 3'h1,
    VBS_SW_D16H = 3'h3,
    VBS_SW_D32 = 3'h2,
    VBS_SW_D64 = 3'h6
  } vbs_swap_t;
  // write settling time and its cycle count at 40 MHz
  localparam int VBS_CLK_MHZ = 40;
  localparam int VBS_SETTLE_NS = 50;
  localparam int VBS_SETTLE_CYC =
    (VBS_SETTLE_NS * VBS_CLK_MHZ + 999) / 1000;
  localparam int VBS_FIFO_DEPTH = 8;
endpackage

/* verilog/vbs_fifo.sv */
`timescale 1ns/1ps
module vbs_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic [AW:0] next_cnt;
  logic room;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  // room is a flop so the writer never sees a gated compare glitch
  assign in_ready = room;
  assign out_valid = (cnt != '0);
  // next occupancy, shared by the count and the room flag
  assign next_cnt = cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign out_data = mem[rp];

  ////////////////////////////////////////////////////////////////////
  // storage has no reset, only pointers, count and room flag do
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      room <= 1'b1;
    end else begin
      if (do_wr) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (do_rd) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      cnt <= next_cnt;
      room <= (next_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule

/* verilog/vbs_swapper.sv */
`timescale 1ns/1ps
// Contract
// - reverse bytes for aligned D16/D32/D64; separate master and slave enables.
// - swapped upper D16 exchanges bits 31:24 with 23:16.
// - swapped lower D16 exchanges bits 15:8 with 7:0.
// - swapped D32 fully reverses four bytes.
// - swapped D64 reverses bytes inside each 32-bit half.
// - decode swappable, check enable, then set multiplexers.
// - reads get their pattern set before data is valid.
// - writes hold off data strobes about 50 ns while muxes settle.
// - delay on single cycles and first block cycle only.
// - no-delay control skips settle; software guarantees all cycles swappable.
// - swap only aligned transfers; D64 handled as two D32 halves.
module vbs_swapper
  import vbs_pkg::*;
#(
  parameter int WIDTH = VBS_DW,
  parameter int DEPTH = VBS_FIFO_DEPTH,
  parameter int SETTLE = VBS_SETTLE_CYC
) (
  input wire logic clk, // 40 MHz board clock
  input wire logic rstn, // async reset, active low
  input wire logic swap_mst_en, // swap enable, master cycles
  input wire logic swap_slv_en, // swap enable, slave cycles
  input wire logic no_delay, // skip write settle delay
  input wire logic cyc_start, // new cycle decode pulse
  input wire logic cyc_master, // 1 board is master
  input wire logic cyc_write, // 1 write cycle
  input wire logic cyc_block, // 1 block transfer
  input wire logic cyc_aligned, // address aligned to width
  input wire logic [1:0] cyc_width, // transfer width code
  input wire logic cyc_lane, // D16 lane: 1 upper
  input wire logic cyc_end, // cycle finished pulse
  input wire logic ds_req, // data strobes wanted, reads and writes
  output logic ds_go, // strobes may be asserted
  output logic [2:0] swap_sel, // current swap pattern
  input wire logic in_valid, // incoming data word
  output logic in_ready, // room in data fifo
  input wire logic [WIDTH-1:0] in_data, // unswapped data
  output logic out_valid, // swapped word valid
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data // swapped data
);
  typedef enum logic [1:0] {
    VBS_IDLE = 2'h0,
    VBS_SETL = 2'h1,
    VBS_RUN = 2'h3
  } vbs_state_t;

  vbs_state_t state;
  vbs_state_t next_state;
  vbs_swap_t pat;
  logic first_done;
  logic [7:0] cnt;
  logic [WIDTH-1:0] f_data;
  logic f_valid;
  logic o_valid;
  logic [WIDTH-1:0] o_data;

  ////////////////////////////////////////////////////////////////////
  // byte reversal of one 32-bit half; reused for both halves
  function automatic logic [31:0] vbs_rev32(input logic [31:0] d);
    vbs_rev32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // exchange the two bytes of one 16-bit lane
  function automatic logic [15:0] vbs_rev16(input logic [15:0] d);
    vbs_rev16 = {d[7:0], d[15:8]};
  endfunction

  // apply a pattern to a full word
  function automatic logic [WIDTH-1:0] vbs_apply(input vbs_swap_t p,
      input logic [WIDTH-1:0] d);
    logic [WIDTH-1:0] r;
    r = d;
    case (p)
      VBS_SW_D16H: r[31:16] = vbs_rev16(d[31:16]);
      VBS_SW_D16L: r[15:0] = vbs_rev16(d[15:0]);
      VBS_SW_D32: r[31:0] = vbs_rev32(d[31:0]);
      VBS_SW_D64: begin
        r[63:32] = vbs_rev32(d[63:32]);
        r[31:0] = vbs_rev32(d[31:0]);
      end
      default: r = d;
    endcase
    vbs_apply = r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode: swappable first, then enable, then pattern
  wire swappable = cyc_aligned && (cyc_width != VBS_W_D08);
  wire enabled = cyc_master ? swap_mst_en : swap_slv_en;
  wire [2:0] w16 = (cyc_lane == VBS_LANE_HI) ? VBS_SW_D16H : VBS_SW_D16L;
  wire [2:0] wpat = (cyc_width == VBS_W_D64) ? VBS_SW_D64 :
                    (cyc_width == VBS_W_D32) ? VBS_SW_D32 : w16;
  wire [2:0] dec_pat = (swappable && enabled) ? wpat : VBS_SW_NONE;
  // a block's later beats and the no-delay mode go straight through
  wire need_settle = cyc_write && !no_delay &&
                     !(cyc_block && first_done);

  // pattern is latched at cycle start, ahead of any read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pat <= VBS_SW_NONE;
    end else if (cyc_start) begin
      pat <= vbs_swap_t'(dec_pat);
    end
  end

  // remembers a block's first beat has been settled already
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_done <= 1'b0;
    end else if (cyc_end && !cyc_block) begin
      first_done <= 1'b0;
    end else if (cyc_start && cyc_block) begin
      first_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // settle sequencer: strobes wait SETTLE cycles after start
  always_comb begin
    next_state = state;
    case (state)
      VBS_IDLE: begin
        if (cyc_start) begin
          next_state = need_settle ? VBS_SETL : VBS_RUN;
        end
      end
      VBS_SETL: begin
        if (cyc_end) begin
          next_state = VBS_IDLE;
        end else if (cnt == 8'(SETTLE - 1)) begin
          next_state = VBS_RUN;
        end
      end
      VBS_RUN: begin
        if (cyc_end) begin
          next_state = VBS_IDLE;
        end
      end
      default: next_state = VBS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= VBS_IDLE;
      cnt <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= (state == VBS_SETL) ? cnt + 8'h01 : 8'h00;
    end
  end

  // strobe release is registered; reads pass straight
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ds_go <= 1'b0;
      swap_sel <= 3'h0;
    end else begin
      ds_go <= ds_req && (next_state == VBS_RUN);
      swap_sel <= pat;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data fifo; its ready stalls the data source
  vbs_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(f_valid),
    .out_ready(!o_valid || out_ready),
    .out_data(f_data)
  );

  // output register keeps outputs straight from flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      o_valid <= 1'b0;
      o_data <= '0;
    end else if (!o_valid || out_ready) begin
      o_valid <= f_valid;
      o_data <= vbs_apply(pat, f_data);
    end
  end

  assign out_valid = o_valid;
  assign out_data = o_data;
endmodule

/* tb/vbs_sink.sv */
`timescale 1ns/1ps
module vbs_sink (
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic hold, // stop taking
  input wire logic valid, // word offered
  input wire logic [63:0] data, // offered word
  output logic ready // taking words
);
  logic [63:0] got[$];
  // takes every other cycle, so the output stage always sees a slow reader
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ready <= 1'b0;
    else ready <= !hold && !ready;
  end
  // keep every accepted word for the bench
  always @(posedge clk) if (valid && ready) got.push_back(data);
endmodule

/* tb/vbs_swapper_monitor.sv */
`timescale 1ns/1ps
module vbs_mon
  import vbs_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic swap_mst_en, // master enable
  input wire logic swap_slv_en, // slave enable
  input wire logic no_delay, // skip settle
  input wire logic cyc_start, // decode pulse
  input wire logic cyc_master, // master cycle
  input wire logic cyc_write, // write cycle
  input wire logic cyc_block, // block beat
  input wire logic cyc_aligned, // aligned
  input wire logic [1:0] cyc_width, // width
  input wire logic cyc_lane, // d16 lane
  input wire logic ds_req, // strobes wanted
  input wire logic ds_go, // strobes allowed
  input wire logic [2:0] swap_sel // pattern
);
  // a start whose enable and alignment allow a swap
  wire en = cyc_master ? swap_mst_en : swap_slv_en;
  wire sw = cyc_start && en && cyc_aligned;
  wire wr = cyc_start && cyc_write && ds_req;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_hold;
    !ds_go [*2];
  endsequence
  ////////////////////////////////////////////////////////////
  // swap_sel copies the latched pattern one edge late: two edges after start
  a_sel_pass: assert property (cyc_start && !(en && cyc_aligned)
    |-> ##2 swap_sel == VBS_SW_NONE) else $error("pass pattern wrong");
  a_sel_byte: assert property (sw && cyc_width == VBS_W_D08
    |-> ##2 swap_sel == VBS_SW_NONE) else $error("d08 pattern wrong");
  a_sel_upper: assert property (sw && cyc_width == VBS_W_D16
    && cyc_lane |-> ##2 swap_sel == VBS_SW_D16H) else $error("d16h wrong");
  a_sel_lower: assert property (sw && cyc_width == VBS_W_D16
    && !cyc_lane |-> ##2 swap_sel == VBS_SW_D16L) else $error("d16l wrong");
  a_sel_quad: assert property (sw && cyc_width == VBS_W_D32
    |-> ##2 swap_sel == VBS_SW_D32) else $error("d32 pattern wrong");
  a_sel_octal: assert property (sw && cyc_width == VBS_W_D64
    |-> ##2 swap_sel == VBS_SW_D64) else $error("d64 pattern wrong");
  a_settle_wait: assert property (wr && !no_delay && !cyc_block
    |=> s_hold ##1 ds_go) else $error("write settle wrong");
  a_skip_delay: assert property (wr && no_delay
    |=> ds_go) else $error("no-delay write held");
  a_read_fast: assert property (cyc_start && !cyc_write && ds_req
    |=> ds_go) else $error("read strobes held");
endmodule
bind vbs_swapper vbs_mon u_vbs_mon (.*);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import vbs_pkg::*;
  logic clk = 0, rstn = 0, swap_mst_en = 0, swap_slv_en = 0, no_delay = 0;
  logic cyc_start = 0, cyc_master = 0, cyc_write = 0, cyc_block = 0;
  logic cyc_aligned = 0, cyc_lane = 0, cyc_end = 0, ds_req = 0;
  logic in_valid = 0, hold = 0, blk = 0;
  logic [1:0] cyc_width = 2'h0;
  logic [63:0] in_data = 64'h0;
  logic ds_go, in_ready, out_valid, out_ready;
  logic [2:0] swap_sel, sel_now;
  logic [63:0] out_data;
  int mismatches = 0, checks_done = 0, ticks = 0;
  localparam logic [63:0] PAT = 64'h0123456789ABCDEF;
  vbs_swapper u_vbs_swapper (.*);
  vbs_sink u_vbs_sink (.clk, .rstn, .hold, .valid(out_valid),
    .data(out_data), .ready(out_ready));
  always #12.5 clk = ~clk;
  // the run needs under a thousand cycles; far past that it has hung
  always @(posedge clk) begin
    ticks++;
    if (ticks == 4000) begin
      mismatches++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk) #2;
  endtask
  task automatic chk_v(input string n, input logic [63:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // expected byte order, from the lane exchange tables
  function automatic logic [63:0] xs(logic [2:0] s, logic [63:0] d);
    case (s)
      VBS_SW_D16L: return {d[63:16], d[7:0], d[15:8]};
      VBS_SW_D16H: return {d[63:32], d[23:16], d[31:24], d[15:0]};
      VBS_SW_D32: return {d[63:32], d[7:0], d[15:8], d[23:16], d[31:24]};
      VBS_SW_D64: return {d[39:32], d[47:40], d[55:48], d[63:56],
        d[7:0], d[15:8], d[23:16], d[31:24]};
      default: return d;
    endcase
  endfunction
  function automatic logic [2:0] esel(logic m, a, logic [1:0] w, logic l);
    if (!(m ? swap_mst_en : swap_slv_en) || !a || w == VBS_W_D08)
      return VBS_SW_NONE;
    if (w == VBS_W_D16) return l ? VBS_SW_D16H : VBS_SW_D16L;
    return w == VBS_W_D32 ? VBS_SW_D32 : VBS_SW_D64;
  endfunction
  // one whole cycle: decode, wait strobes, push one word, finish
  task automatic run_cyc(logic m, w, b, a, logic [1:0] wd, logic l);
    int n;
    int ew;
    ew = (w && !no_delay && !(b && blk)) ? VBS_SETTLE_CYC + 1 : 1;
    blk = b;
    sel_now = esel(m, a, wd, l);
    step();
    {cyc_master, cyc_write, cyc_block, cyc_aligned} = {m, w, b, a};
    {cyc_width, cyc_lane, cyc_start, ds_req} = {wd, l, 2'b11};
    step();
    cyc_start = 0;
    n = 1;
    while (ds_go !== 1'b1 && n < 8) begin
      step();
      n++;
    end
    chk_v("go_delay", 64'(ew), 64'(n));
    in_data = PAT;
    in_valid = 1;
    step();
    in_valid = 0;
    // swap_sel trails the start edge by one edge; look once it stands
    chk_v("sel", 64'(sel_now), 64'(swap_sel));
    n = 0;
    while (u_vbs_sink.got.size() == 0 && n < 20) begin
      step();
      n++;
    end
    chk_v("data", xs(sel_now, PAT), u_vbs_sink.got.pop_front());
    {cyc_end, ds_req} = 2'b10;
    step();
    cyc_end = 0;
    repeat (2) step();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_widths();
    swap_mst_en = 1;
    for (int i = 0; i < 8; i++) run_cyc(1, 1, 0, 1, i[2:1], i[0]);
    $display("widths done");
  endtask
  task automatic t_slave();
    {swap_mst_en, swap_slv_en} = 2'b01;
    run_cyc(0, 0, 0, 1, VBS_W_D32, 0);
    run_cyc(1, 1, 0, 1, VBS_W_D32, 0);
    run_cyc(0, 1, 0, 0, VBS_W_D16, 1);
    $display("slave done");
  endtask
  task automatic t_block();
    swap_mst_en = 1;
    repeat (3) run_cyc(1, 1, 1, 1, VBS_W_D64, 0);
    run_cyc(1, 1, 0, 1, VBS_W_D32, 0);
    no_delay = 1;
    run_cyc(1, 1, 0, 1, VBS_W_D64, 0);
    no_delay = 0;
    $display("block done");
  endtask
  // fill against a stopped reader until refused, then drain it empty
  task automatic t_fifo();
    int k;
    int t;
    {hold, in_valid, k, t} = {2'b11, 64'h0};
    while (in_ready === 1'b1 && k < 12) begin
      in_data = 64'(k);
      step();
      k++;
    end
    in_valid = 0;
    chk_v("fill", 64'h1, 64'(k >= VBS_FIFO_DEPTH && in_ready === 1'b0));
    hold = 0;
    while (u_vbs_sink.got.size() < k && t < 60) begin
      step();
      t++;
    end
    for (int i = 0; i < k; i++)
      chk_v("drain", xs(sel_now, 64'(i)), u_vbs_sink.got.pop_front());
    chk_v("empty", 64'h0, 64'(out_valid));
    $display("fifo done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #2 rstn = 1;
    t_widths();
    t_slave();
    t_block();
    t_fifo();
    finish_test();
  end
endmodule
